// ===== hdl/hus_defines.vh
// register map, field positions, reset values and rates for the host uart
`ifndef HUS_DEFINES_VH
`define HUS_DEFINES_VH

// register indices; byte address on the bus is four times the index
`define HUS_IDX_DATA 3'h0
`define HUS_IDX_IER 3'h1
`define HUS_IDX_IIR 3'h2
`define HUS_IDX_LCR 3'h3
`define HUS_IDX_MCR 3'h4
`define HUS_IDX_LSR 3'h5
`define HUS_IDX_MSR 3'h6
`define HUS_IDX_SCR 3'h7

// line control fields
`define HUS_LCR_DIVSEL 7
`define HUS_LCR_BREAK 6
`define HUS_LCR_STICK 5
`define HUS_LCR_EVEN 4
`define HUS_LCR_PAREN 3
`define HUS_LCR_STOP2 2

// modem control outputs fields
`define HUS_MCR_LOOP 4
`define HUS_MCR_USER_OUTPUT_TWO 3
`define HUS_MCR_USER_OUTPUT_ONE 2
`define HUS_MCR_RTS 1
`define HUS_MCR_DTR 0

// fifo control fields
`define HUS_FCR_EN 0
`define HUS_FCR_RXCLR 1
`define HUS_FCR_TXCLR 2

// interrupt identification codes
`define HUS_IID_NONE 4'h1
`define HUS_IID_LINE 4'h6
`define HUS_IID_RDA 4'h4
`define HUS_IID_TMO 4'hC
`define HUS_IID_HOLDING_EMPTY_FLAG 4'h2
`define HUS_IID_MODEM 4'h0

// receive trigger levels selected by the two-bit field
`define HUS_TRIG_0 5'h01
`define HUS_TRIG_1 5'h04
`define HUS_TRIG_2 5'h08
`define HUS_TRIG_3 5'h0E

// baud base rate and the rate used for a zero divisor
`define HUS_BAUD_BASE 115200
`define HUS_BAUD_ZERO 230400
`define HUS_CLK_HZ 20000000

// reset values and the receive timeout length in characters
`define HUS_RST_LCR 8'h03
`define HUS_RST_DIV 16'h000C
`define HUS_TO_CHARS 3'h4

`endif

// ===== hdl/hus_uart_top.v
// host side uart: status flags, buffers, divisor, fifo interrupts
//
// Summary of operation
// - overrun set on unread overwrite, cleared reading status
// - fifo mode: overrun only when fifo full
// - receive ready set on char, cleared on read
// - fifo mode: ready while fifo non-empty
// - modem status: states high, changes low nibble
// - any change bit raises modem status interrupt
// - carrier and ring states, loopback mirrors outputs
// - set-ready state, loopback mirrors terminal-ready
// - clear-to-send state, loopback mirrors request-to-send
// - carrier, set-ready, clear-send change flags
// - ring change flag only on falling edge
// - offset 0 read returns oldest received char
// - offset 0 write loads transmit, lsb first
// - divisor select maps offsets 0,1 to divisor
// - baud equals 115200 over divisor, zero fast
// - offset 7 scratch byte, no side effect
// - fifo receive interrupts need fifo and enable
// - data-available code at trigger level
// - timeout after four idle character times
// - transmit-empty code, cleared by write or id
// - delay empty indication when fifo barely used
// - first empty after fifo enable is immediate
// - interrupt line driven only with output two
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`include "hus_defines.vh"

module hus_fifo #(
   parameter DW = 8,
   parameter AW = 4
) (
   input wire clk_i, // system clock
   input wire rst_i, // synchronous reset
   input wire ce_i, // clock enable
   input wire clr_i, // flush contents
   input wire push_i, // write strobe
   input wire pop_i, // read strobe
   input wire [DW-1:0] din_i, // write data
   output wire [DW-1:0] dout_o, // oldest entry
   output reg [AW:0] cnt_o // entries held
);
   reg [DW-1:0] mem [0:(1<<AW)-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   wire do_pop;
   wire do_push;

   assign dout_o = mem[rp_r];
   assign do_pop = pop_i && (cnt_o != 0);
   assign do_push = push_i && (do_pop || cnt_o != (1 << AW));

   // pointers and count; a push into a full fifo is dropped unless a pop comes in the same cycle
   always @(posedge clk_i) begin
      if (rst_i || (ce_i && clr_i)) begin
         wp_r <= {AW{1'b0}};
         rp_r <= {AW{1'b0}};
         cnt_o <= {(AW+1){1'b0}};
      end else if (ce_i) begin
         if (do_push) begin
            mem[wp_r] <= din_i;
            wp_r <= wp_r + 1'b1;
         end
         if (do_pop)
            rp_r <= rp_r + 1'b1;
         if (do_push && !do_pop)
            cnt_o <= cnt_o + 1'b1;
         else if (do_pop && !do_push)
            cnt_o <= cnt_o - 1'b1;
      end
   end
endmodule

module hus_uart_top #(
   parameter CLK_HZ = `HUS_CLK_HZ,
   parameter DEPTH_LOG2 = 4
) (
   input wire clk_i, // system clock
   input wire rst_i, // synchronous reset, high
   input wire ce_i, // clock enable
   input wire wb_cyc_i, // bus cycle
   input wire wb_stb_i, // bus strobe
   input wire wb_we_i, // bus write
   input wire [4:0] wb_adr_i, // byte address
   input wire [3:0] wb_sel_i, // byte lanes
   input wire [31:0] wb_dat_i, // write data
   output wire [31:0] wb_dat_o, // read data
   output wire wb_ack_o, // acknowledge
   input wire rx_valid_i, // received char strobe
   input wire [7:0] rx_data_i, // received char
   input wire dcd_i, // carrier detect state
   input wire ri_i, // ring indicator state
   input wire dsr_i, // data set ready state
   input wire cts_i, // clear to send state
   output wire sout_o, // serial transmit data
   output wire dtr_o, // terminal ready
   output wire rts_o, // request to send
   output wire irq_o, // host interrupt line level
   output wire irq_oe_o // host interrupt line enable
);
   localparam CW = DEPTH_LOG2 + 1;
   localparam [CW-1:0] DEPTH = {1'b1, {DEPTH_LOG2{1'b0}}};
   localparam [47:0] CLK48 = CLK_HZ;

   reg ack_r;
   reg [7:0] dat_r;
   reg [7:0] ier_r;
   reg [7:0] lcr_r;
   reg [7:0] mcr_r;
   reg [7:0] scr_r;
   reg [15:0] div_r;
   reg fifo_en_r;
   reg [1:0] trig_sel_r;
   reg oe_r;
   reg [3:0] delta_r;
   reg [3:0] msr_prev_r;
   reg [47:0] acc_r;
   reg tick_r;
   reg [6:0] to_cnt_r;
   reg busy_r;
   reg [11:0] frame_r;
   reg [3:0] nbits_r;
   reg [7:0] lb_data_r;
   reg sout_r;
   reg holding_empty_flag_q_r;
   reg holding_empty_flag_int_r;
   reg two_seen_r;
   reg first_r;
   reg dly_act_r;
   reg [3:0] dly_r;
   reg irq_r;

   wire take = ce_i && wb_cyc_i && wb_stb_i && !ack_r;
   wire [2:0] idx = wb_adr_i[4:2];
   wire wr = take && wb_we_i && wb_sel_i[0];
   wire rd = take && !wb_we_i;
   wire divsel = lcr_r[`HUS_LCR_DIVSEL];
   wire loop = mcr_r[`HUS_MCR_LOOP];

   // fifo and frame derived values
   wire [CW-1:0] rx_cnt;
   wire [CW-1:0] tx_cnt;
   wire [7:0] rx_dout;
   wire [7:0] tx_dout;
   wire [3:0] wlen = {2'b00, lcr_r[1:0]} + 4'h5;
   wire [3:0] charbits = 4'h1 + wlen + {3'b000, lcr_r[`HUS_LCR_PAREN]} +
                         (lcr_r[`HUS_LCR_STOP2] ? 4'h2 : 4'h1);
   wire [6:0] to_lim = {3'b000, charbits} * {4'h0, `HUS_TO_CHARS};
   reg [CW-1:0] trig;
   reg [11:0] frm;
   reg par;
   reg [7:0] dmask;
   integer i;

   // rx path; loopback pushes frame_r[8:1] into the receiver as each tx char completes
   wire lb_push = busy_r && tick_r && nbits_r == 4'h1 && loop;
   wire rx_push = loop ? lb_push : (ce_i && rx_valid_i);
   wire [7:0] rx_din = loop ? frame_r[8:1] & dmask : rx_data_i;
   wire rx_full = fifo_en_r ? (rx_cnt == DEPTH) : (rx_cnt != 0);
   wire rx_over = rx_push && rx_full;
   wire rd_rbr = rd && idx == `HUS_IDX_DATA && !divsel;
   wire rx_pop = rd_rbr || (rx_over && !fifo_en_r);
   wire wr_thr = wr && idx == `HUS_IDX_DATA && !divsel;
   wire tx_full = fifo_en_r ? (tx_cnt == DEPTH) : (tx_cnt != 0);
   wire tx_load = !busy_r && tx_cnt != 0;
   wire holding_empty_flag = tx_cnt == 0;
   wire temt = holding_empty_flag && !busy_r;
   wire wr_fcr = wr && idx == `HUS_IDX_IIR;
   wire fcr_clr = wr_fcr && wb_dat_i[`HUS_FCR_EN] != fifo_en_r;

   // modem state mux; loopback ties the control outputs back
   wire [3:0] msr_cur = loop ? {mcr_r[`HUS_MCR_USER_OUTPUT_TWO], mcr_r[`HUS_MCR_USER_OUTPUT_ONE],
                                mcr_r[`HUS_MCR_DTR], mcr_r[`HUS_MCR_RTS]}
                             : {dcd_i, ri_i, dsr_i, cts_i};
   wire [3:0] msr_evt = {msr_cur[3] ^ msr_prev_r[3],
                         msr_prev_r[2] & ~msr_cur[2],
                         msr_cur[1] ^ msr_prev_r[1],
                         msr_cur[0] ^ msr_prev_r[0]};

   // interrupt sources in priority order
   wire timeout = rx_cnt != 0 && to_cnt_r >= to_lim;
   wire int_line = ier_r[2] && oe_r;
   wire int_rda = ier_r[0] && (fifo_en_r ? rx_cnt >= trig
                                         : rx_cnt != 0);
   wire int_tmo = ier_r[0] && fifo_en_r && timeout;
   wire int_thr = ier_r[1] && holding_empty_flag_int_r;
   wire int_ms = ier_r[3] && delta_r != 4'h0;
   reg [3:0] iid;
   reg [7:0] rd_mux;

   hus_fifo #(.DW(8), .AW(DEPTH_LOG2)) u_rxf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .clr_i(fcr_clr || (wr_fcr && wb_dat_i[`HUS_FCR_RXCLR])),
      .push_i(rx_push),
      .pop_i(rx_pop),
      .din_i(rx_din),
      .dout_o(rx_dout),
      .cnt_o(rx_cnt)
   );

   hus_fifo #(.DW(8), .AW(DEPTH_LOG2)) u_txf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .clr_i(fcr_clr || (wr_fcr && wb_dat_i[`HUS_FCR_TXCLR])),
      .push_i(wr_thr && !tx_full),
      .pop_i(tx_load),
      .din_i(wb_dat_i[7:0]),
      .dout_o(tx_dout),
      .cnt_o(tx_cnt)
   );

   // trigger level, interrupt id and transmit frame assembly
   always @* begin
      case (trig_sel_r)
         2'b00: trig = `HUS_TRIG_0;
         2'b01: trig = `HUS_TRIG_1;
         2'b10: trig = `HUS_TRIG_2;
         default: trig = `HUS_TRIG_3;
      endcase
      if (int_line)
         iid = `HUS_IID_LINE;
      else if (int_rda)
         iid = `HUS_IID_RDA;
      else if (int_tmo)
         iid = `HUS_IID_TMO;
      else if (int_thr)
         iid = `HUS_IID_HOLDING_EMPTY_FLAG;
      else if (int_ms)
         iid = `HUS_IID_MODEM;
      else
         iid = `HUS_IID_NONE;
      dmask = 8'hFF >> (4'h8 - wlen);
      if (lcr_r[`HUS_LCR_STICK])
         par = ~lcr_r[`HUS_LCR_EVEN];
      else
         par = lcr_r[`HUS_LCR_EVEN] ? ^(tx_dout & dmask)
                                    : ~^(tx_dout & dmask);
      // start bit then data lsb first, parity, stop bits as ones
      frm = 12'hFFE;
      for (i = 0; i < 8; i = i + 1) begin
         if (i < wlen)
            frm[i+1] = tx_dout[i];
      end
      if (lcr_r[`HUS_LCR_PAREN])
         frm[wlen+1] = par;
   end

   // read data mux; bits above the byte read as zero
   always @* begin
      case (idx)
         `HUS_IDX_DATA: rd_mux = divsel ? div_r[7:0] : rx_dout;
         `HUS_IDX_IER: rd_mux = divsel ? div_r[15:8] : ier_r;
         `HUS_IDX_IIR: rd_mux = {fifo_en_r, fifo_en_r, 2'b00, iid};
         `HUS_IDX_LCR: rd_mux = lcr_r;
         `HUS_IDX_MCR: rd_mux = mcr_r;
         `HUS_IDX_LSR: rd_mux = {1'b0, temt, holding_empty_flag, 3'b000, oe_r,
                                 rx_cnt != 0};
         `HUS_IDX_MSR: rd_mux = {msr_cur, delta_r};
         default: rd_mux = scr_r;
      endcase
   end

   // bus slave: one wait state, ack dropped the cycle after
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 8'h00;
      end else if (ce_i) begin
         ack_r <= take;
         if (rd)
            dat_r <= rd_mux;
      end
   end

   // host written registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         ier_r <= 8'h00;
         lcr_r <= `HUS_RST_LCR;
         mcr_r <= 8'h00;
         scr_r <= 8'h00;
         div_r <= `HUS_RST_DIV;
         fifo_en_r <= 1'b0;
         trig_sel_r <= 2'b00;
      end else if (wr) begin
         case (idx)
            `HUS_IDX_DATA: if (divsel) div_r[7:0] <= wb_dat_i[7:0];
            `HUS_IDX_IER: begin
               if (divsel)
                  div_r[15:8] <= wb_dat_i[7:0];
               else
                  ier_r <= {4'h0, wb_dat_i[3:0]};
            end
            `HUS_IDX_IIR: begin
               fifo_en_r <= wb_dat_i[`HUS_FCR_EN];
               trig_sel_r <= wb_dat_i[7:6];
            end
            `HUS_IDX_LCR: lcr_r <= wb_dat_i[7:0];
            `HUS_IDX_MCR: mcr_r <= {3'b000, wb_dat_i[4:0]};
            `HUS_IDX_SCR: scr_r <= wb_dat_i[7:0];
            default: scr_r <= scr_r;
         endcase
      end
   end

   // overrun and modem change flags; a set wins over the read clear
   always @(posedge clk_i) begin
      if (rst_i) begin
         oe_r <= 1'b0;
         delta_r <= 4'h0;
         msr_prev_r <= 4'h0;
      end else if (ce_i) begin
         msr_prev_r <= msr_cur;
         if (rx_over)
            oe_r <= 1'b1;
         else if (rd && idx == `HUS_IDX_LSR)
            oe_r <= 1'b0;
         if (rd && idx == `HUS_IDX_MSR)
            delta_r <= msr_evt;
         else
            delta_r <= delta_r | msr_evt;
      end
   end

   // fractional baud generator: tick rate is base over divisor; restarted
   // at each frame load so the start bit is never cut short
   always @(posedge clk_i) begin : baud
      reg [47:0] sum;
      reg [47:0] lim;
      sum = acc_r + ((div_r == 16'h0000) ? 48'd`HUS_BAUD_ZERO
                                          : 48'd`HUS_BAUD_BASE);
      lim = CLK48 * ((div_r == 16'h0000) ? 48'd1 : {32'h0, div_r});
      if (rst_i || (ce_i && tx_load)) begin
         acc_r <= 48'h0;
         tick_r <= 1'b0;
      end else if (ce_i) begin
         tick_r <= sum >= lim;
         acc_r <= (sum >= lim) ? sum - lim : sum;
      end
   end

   // idle timer in bit periods, restarted by receive fifo pushes and reads and while that fifo is empty
   always @(posedge clk_i) begin
      if (rst_i)
         to_cnt_r <= 7'h00;
      else if (ce_i) begin
         if (rx_push || rd_rbr || rx_cnt == 0)
            to_cnt_r <= 7'h00;
         else if (tick_r && to_cnt_r != 7'h7F)
            to_cnt_r <= to_cnt_r + 7'h01;
      end
   end

   // transmit shifter; serial line held at mark in loopback
   always @(posedge clk_i) begin
      if (rst_i) begin
         busy_r <= 1'b0;
         frame_r <= 12'hFFF;
         nbits_r <= 4'h0;
         lb_data_r <= 8'h00;
         sout_r <= 1'b1;
      end else if (ce_i) begin
         sout_r <= (loop || !busy_r) ? 1'b1
                   : frame_r[0] & ~lcr_r[`HUS_LCR_BREAK];
         if (tx_load) begin
            busy_r <= 1'b1;
            frame_r <= frm;
            nbits_r <= charbits;
            lb_data_r <= tx_dout;
         end else if (busy_r && tick_r) begin
            frame_r <= {1'b1, frame_r[11:1]};
            nbits_r <= nbits_r - 4'h1;
            if (nbits_r == 4'h1)
               busy_r <= 1'b0;
         end
      end
   end

   // transmit-empty interrupt with the short-burst delay
   always @(posedge clk_i) begin
      if (rst_i) begin
         holding_empty_flag_q_r <= 1'b0;
         holding_empty_flag_int_r <= 1'b0;
         two_seen_r <= 1'b0;
         first_r <= 1'b0;
         dly_act_r <= 1'b0;
         dly_r <= 4'h0;
      end else if (ce_i) begin
         holding_empty_flag_q_r <= holding_empty_flag;
         if (tx_cnt >= 2)
            two_seen_r <= 1'b1;
         if (wr_fcr && wb_dat_i[`HUS_FCR_EN] && !fifo_en_r)
            first_r <= 1'b1;
         // only a fresh empty edge raises it; first_r just skips the delay
         if (holding_empty_flag && !holding_empty_flag_q_r && !holding_empty_flag_int_r) begin
            two_seen_r <= 1'b0;
            first_r <= 1'b0;
            if (fifo_en_r && !two_seen_r && !first_r) begin
               dly_act_r <= 1'b1;
               dly_r <= charbits - 4'h1;
            end else
               holding_empty_flag_int_r <= 1'b1;
         end else if (dly_act_r && tick_r) begin
            if (dly_r <= 4'h1) begin
               dly_act_r <= 1'b0;
               holding_empty_flag_int_r <= 1'b1;
            end else
               dly_r <= dly_r - 4'h1;
         end else if (wr_thr) begin
            holding_empty_flag_int_r <= 1'b0;
            dly_act_r <= 1'b0;
         end else if (rd && idx == `HUS_IDX_IIR && iid == `HUS_IID_HOLDING_EMPTY_FLAG)
            holding_empty_flag_int_r <= 1'b0;
      end
   end

   // interrupt line level registered for a clean output
   always @(posedge clk_i) begin
      if (rst_i)
         irq_r <= 1'b0;
      else if (ce_i)
         irq_r <= iid != `HUS_IID_NONE;
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = {24'h000000, dat_r};
   assign sout_o = sout_r;
   assign dtr_o = mcr_r[`HUS_MCR_DTR];
   assign rts_o = mcr_r[`HUS_MCR_RTS];
   assign irq_o = irq_r;
   assign irq_oe_o = mcr_r[`HUS_MCR_USER_OUTPUT_TWO];
endmodule

// ===== tb/hus_uart_top_chk.sv
// port-level assertions for the host uart top
`timescale 1ns/1ps
module hus_uart_chk (
   input wire clk_i, // system clock
   input wire rst_i, // synchronous reset
   input wire ce_i, // clock enable
   input wire wb_cyc_i, // bus cycle
   input wire wb_stb_i, // bus strobe
   input wire wb_we_i, // bus write
   input wire [4:0] wb_adr_i, // byte address
   input wire [3:0] wb_sel_i, // byte lanes
   input wire [31:0] wb_dat_i, // write data
   input wire [31:0] wb_dat_o, // read data
   input wire wb_ack_o, // acknowledge
   input wire rx_valid_i, // received char strobe
   input wire dcd_i, // carrier state
   input wire ri_i, // ring state
   input wire dsr_i, // set ready state
   input wire cts_i, // clear to send state
   input wire dtr_o, // terminal ready
   input wire rts_o, // request to send
   input wire irq_oe_o // interrupt pin enable
);
   wire tk = wb_cyc_i & wb_stb_i & ce_i & ~wb_ack_o;
   wire [2:0] idx = wb_adr_i[4:2];
   wire rd = tk & ~wb_we_i;
   wire wr = tk & wb_we_i & wb_sel_i[0];
   wire mcr_wr = wr & (idx == 3'h4);
   wire [3:0] ln = {dcd_i, ri_i, dsr_i, cts_i};
   reg oe_ok_r;
   reg msr_ok_r;
   reg [7:0] scr_r;
   reg [3:0] ln1_r;
   reg [3:0] ln2_r;
   // any write or a line change in the last two cycles may set a delta
   wire chg = (ln != ln1_r) | (ln1_r != ln2_r) | wr;

   // track when status reads must come back clean; clear beats set
   always @(posedge clk_i) begin
      if (rst_i) begin
         oe_ok_r <= 1'b0;
         msr_ok_r <= 1'b0;
         scr_r <= 8'h00;
         ln1_r <= 4'h0;
         ln2_r <= 4'h0;
      end else begin
         oe_ok_r <= (oe_ok_r | (rd & idx == 3'h5)) & ~(rx_valid_i & ce_i);
         msr_ok_r <= (msr_ok_r | (rd & idx == 3'h6)) & ~chg;
         if (wr && idx == 3'h7)
            scr_r <= wb_dat_i[7:0];
         ln1_r <= ln;
         ln2_r <= ln1_r;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_ack_next;
      tk |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("no ack");
   property p_ack_cause;
      wb_ack_o |-> $past(tk);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_hi_zero;
      wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper bits");
   property p_oe_clr;
      rd && idx == 3'h5 && oe_ok_r |=> wb_dat_o[1] == 1'b0;
   endproperty
   a_oe_clr: assert property (p_oe_clr) else $error("overrun kept");
   property p_msr_clr;
      rd && idx == 3'h6 && msr_ok_r |=> wb_dat_o[3:0] == 4'h0;
   endproperty
   a_msr_clr: assert property (p_msr_clr) else $error("delta kept");
   property p_scr;
      rd && idx == 3'h7 |=> wb_dat_o[7:0] == scr_r;
   endproperty
   a_scr: assert property (p_scr) else $error("scratch lost");
   property p_oe_pin;
      mcr_wr |=> irq_oe_o == $past(wb_dat_i[3]);
   endproperty
   a_oe_pin: assert property (p_oe_pin) else $error("pin enable");
   property p_oe_hold;
      !$past(rst_i) && !$past(mcr_wr) |-> $stable(irq_oe_o);
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("enable moved");
   property p_mode_pins;
      mcr_wr && !wb_dat_i[4] |=> dtr_o == $past(wb_dat_i[0])
         && rts_o == $past(wb_dat_i[1]);
   endproperty
   a_mode_pins: assert property (p_mode_pins) else $error("dtr rts");
endmodule

bind hus_uart_top hus_uart_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .rx_valid_i(rx_valid_i), .dcd_i(dcd_i), .ri_i(ri_i), .dsr_i(dsr_i),
   .cts_i(cts_i), .dtr_o(dtr_o), .rts_o(rts_o), .irq_oe_o(irq_oe_o));

// ===== tb/hus_modem_model.sv
// modem side model: received chars, line states, serial capture
`timescale 1ns/1ps
module hus_modem_model (
   input wire clk_i, // system clock
   input wire sout_i, // serial data from the block
   output logic rx_valid_o, // char strobe
   output logic [7:0] rx_data_o, // char, bit0 first on the line
   output logic [3:0] lines_o // carrier, ring, set ready, clear send
);
   initial begin
      rx_valid_o = 1'b0;
      rx_data_o = 8'hFF;
      lines_o = 4'h0;
   end

   // one-cycle strobe; data is inverted after so nothing stale looks valid
   task send(input logic [7:0] c);
      begin
         rx_valid_o <= 1'b1;
         rx_data_o <= c;
         @(posedge clk_i);
         rx_valid_o <= 1'b0;
         rx_data_o <= ~c;
         @(posedge clk_i);
      end
   endtask

   // new line levels, then a few cycles for the block to see them
   task set_lines(input logic [3:0] v);
      begin
         lines_o <= v;
         repeat (3) @(posedge clk_i);
      end
   endtask

   // sample each bit mid-period; ok says start and stop were right
   task recv(input integer per, output logic [7:0] b, output logic ok);
      integer n;
      integer k;
      begin
         n = 0;
         while (sout_i && n < 4000) begin
            @(negedge clk_i);
            n = n + 1;
         end
         repeat (per / 2) @(negedge clk_i);
         ok = !sout_i;
         for (k = 0; k < 8; k = k + 1) begin
            repeat (per) @(negedge clk_i);
            b[k] = sout_i;
         end
         repeat (per) @(negedge clk_i);
         ok = ok & sout_i;
      end
   endtask
endmodule

// ===== tb/hus_uart_top_tb.sv
// self-checking bench for the host uart top
`timescale 1ns/1ps
module hus_uart_top_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [4:0] wb_adr_i = 5'h00;
   logic [31:0] wb_dat_i = 32'h00000000;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, sout_o, dtr_o, rts_o, irq_o, irq_oe_o, rx_valid;
   wire [7:0] rx_data;
   wire [3:0] lines;
   integer bad_count = 0;
   integer n_tests = 0;
   integer cyc_n = 0;
   integer i;
   logic [7:0] q;
   logic ok;
   logic [3:0] lv [0:4] = '{4'h8, 4'hC, 4'h8, 4'hA, 4'hB};
   logic [7:0] mv [0:4] = '{8'h88, 8'hC0, 8'h84, 8'hA2, 8'hB1};

   always #25 clk_i = ~clk_i;

   hus_uart_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid),
      .rx_data_i(rx_data), .dcd_i(lines[3]), .ri_i(lines[2]),
      .dsr_i(lines[1]), .cts_i(lines[0]), .sout_o(sout_o), .dtr_o(dtr_o),
      .rts_o(rts_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o));
   hus_modem_model mdl_u (.clk_i(clk_i), .sout_i(sout_o),
      .rx_valid_o(rx_valid), .rx_data_o(rx_data), .lines_o(lines));

   task stop_test;
      begin
         $display("checks %0d mismatches %0d", n_tests, bad_count);
         if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask

   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
         end
      end
   endtask

   // classic cycle held until ack is sampled at a rising edge, then one
   // idle cycle; values read right after the edge are the pre-edge ones
   task bus(input logic [2:0] x, input logic w, input logic [7:0] d);
      integer n;
      begin
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_adr_i <= {x, 2'b00};
         wb_dat_i <= {24'h000000, d};
         n = 0;
         do begin
            @(posedge clk_i);
            n = n + 1;
         end while (wb_ack_o !== 1'b1 && n < 16);
         chk("ack", 8'h01, {7'h00, wb_ack_o});
         q = wb_dat_o[7:0];
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask

   task rd(input logic [2:0] x, input string nm, input logic [7:0] e,
      input logic [7:0] m);
      begin
         bus(x, 1'b0, 8'h00);
         chk(nm, e, q & m);
      end
   endtask

   // irq is registered, so look at it mid-cycle
   task chk_irq(input logic e);
      begin
         @(negedge clk_i);
         chk("irq", {7'h00, e}, {7'h00, irq_o});
         @(posedge clk_i);
      end
   endtask

   task t_regs;
      begin
         bus(3'h7, 1'b1, 8'hA5);
         rd(3'h7, "scratch", 8'hA5, 8'hFF);
         bus(3'h3, 1'b1, 8'h83);
         rd(3'h0, "div_lo", 8'h0C, 8'hFF);
         bus(3'h1, 1'b1, 8'h06);
         bus(3'h0, 1'b1, 8'h00);
         rd(3'h1, "div_hi", 8'h06, 8'hFF);
         rd(3'h0, "div_lo", 8'h00, 8'hFF);
         bus(3'h3, 1'b1, 8'h03);
         rd(3'h7, "scratch", 8'hA5, 8'hFF);
      end
   endtask

   task t_msr;
      begin
         bus(3'h1, 1'b1, 8'h08);
         for (i = 0; i < 5; i = i + 1) begin
            mdl_u.set_lines(lv[i]);
            rd(3'h2, "iid", (mv[i][3:0] != 4'h0) ? 8'h00 : 8'h01, 8'hFF);
            rd(3'h6, "msr", mv[i], 8'hFF);
            rd(3'h6, "msr_again", 8'h00, 8'h0F);
            rd(3'h2, "iid", 8'h01, 8'hFF);
         end
         bus(3'h4, 1'b1, 8'h1F);
         rd(3'h6, "msr_loop", 8'hF0, 8'hF0);
         bus(3'h4, 1'b1, 8'h11);
         rd(3'h6, "msr_loop", 8'h20, 8'hF0);
         bus(3'h4, 1'b1, 8'h12);
         rd(3'h6, "msr_loop", 8'h10, 8'hF0);
         bus(3'h4, 1'b1, 8'h08);
         rd(3'h6, "msr", 8'hB0, 8'hF0);
         bus(3'h1, 1'b1, 8'h00);
      end
   endtask

   task t_rx;
      begin
         mdl_u.send(8'h5A);
         rd(3'h5, "ready", 8'h01, 8'h03);
         mdl_u.send(8'h11);
         mdl_u.send(8'h22);
         rd(3'h5, "overrun", 8'h03, 8'h03);
         rd(3'h5, "overrun", 8'h01, 8'h03);
         rd(3'h0, "rx_data", 8'h22, 8'hFF);
         rd(3'h5, "ready", 8'h00, 8'h03);
      end
   endtask

   // fill to the trigger of 14, past full, then drain in order
   task t_fifo;
      begin
         bus(3'h1, 1'b1, 8'h01);
         bus(3'h2, 1'b1, 8'hC1);
         for (i = 0; i < 17; i = i + 1) begin
            mdl_u.send(8'h30 + i[7:0]);
            if (i == 12) begin
               rd(3'h2, "iid", 8'hC1, 8'hFF);
               rd(3'h5, "ready", 8'h01, 8'h03);
               chk_irq(1'b0);
            end
            if (i == 13) begin
               rd(3'h2, "iid", 8'hC4, 8'hFF);
               chk_irq(1'b1);
            end
            if (i == 15)
               rd(3'h5, "full", 8'h01, 8'h03);
         end
         rd(3'h5, "overrun", 8'h03, 8'h03);
         for (i = 0; i < 16; i = i + 1) begin
            rd(3'h0, "rx_fifo", 8'h30 + i[7:0], 8'hFF);
            if (i == 2)
               chk_irq(1'b0);
         end
         rd(3'h5, "ready", 8'h00, 8'h03);
      end
   endtask

   // divisor 1 then 0: about 174 and 87 clocks per bit
   task t_tx;
      begin
         bus(3'h1, 1'b1, 8'h02);
         rd(3'h2, "iid", 8'hC2, 8'hFF);
         rd(3'h2, "iid", 8'hC1, 8'hFF);
         for (i = 0; i < 2; i = i + 1) begin
            bus(3'h3, 1'b1, 8'h83);
            bus(3'h0, 1'b1, (i == 0) ? 8'h01 : 8'h00);
            bus(3'h1, 1'b1, 8'h00);
            bus(3'h3, 1'b1, 8'h03);
            bus(3'h0, 1'b1, (i == 0) ? 8'hA5 : 8'h3C);
            mdl_u.recv((i == 0) ? 174 : 87, q, ok);
            chk("tx_frame", 8'h01, {7'h00, ok});
            chk("tx_byte", (i == 0) ? 8'hA5 : 8'h3C, q);
            @(posedge clk_i);
         end
      end
   endtask

   // one char left unread past four char times at 230400 baud
   task t_tmo;
      begin
         bus(3'h1, 1'b1, 8'h03);
         mdl_u.send(8'h77);
         repeat (3300) @(posedge clk_i);
         rd(3'h2, "no_tmo", 8'h00, 8'h0C);
         repeat (300) @(posedge clk_i);
         rd(3'h2, "tmo", 8'hCC, 8'hFF);
         rd(3'h0, "rx_tmo", 8'h77, 8'hFF);
         rd(3'h2, "tmo_gone", 8'h00, 8'h0C);
      end
   endtask

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs;
      t_msr;
      t_rx;
      t_fifo;
      t_tx;
      t_tmo;
      stop_test;
   end

   // hang guard, well above the few thousand cycles the run needs
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         bad_count = bad_count + 1;
         stop_test;
      end
   end
endmodule
